// file: hdl/axs_params.svh
// Behaviour
// RQ1 - Input status query answers one five-character token per input: letter, four hex.
// RQ2 - Letter: T unmuted unlocked, L locked, M muted, U muted and locked.
// RQ3 - Low byte bits 3-2 signal presence, bits 1-0 connection; 11 yes, 10 no, 00 unknown.
// RQ4 - First and second inputs always report connection 00 (unknown).
// RQ5 - All status bits above the low four report as zero.
// RQ6 - Output status query gives one token per output, in order, semicolon separated.
// RQ7 - Routing list query gives the input routed to each output, in output order.
// RQ8 - Switch command routes the named input to the named output and is acknowledged.
// RQ9 - One input may drive several outputs; each output keeps its own selection.
// RQ10 - Switch changes only the named output; queries report state when serviced.
// RQ11 - Host may mute or unmute one input; its status letter follows.
`ifndef AXS_PARAMS_SVH
`define AXS_PARAMS_SVH

`define AXS_NUM_PORTS 3
`define AXS_FIFO_DEPTH 16
`define AXS_CH_T 8'h54
`define AXS_CH_L 8'h4C
`define AXS_CH_M 8'h4D
`define AXS_CH_U 8'h55
`define AXS_CH_A 8'h41
`define AXS_CH_ZERO 8'h30
`define AXS_CH_SEMI 8'h3B
`define AXS_CH_CR 8'h0D
`define AXS_CH_K 8'h4B
`define AXS_FLD_YES 2'h3
`define AXS_FLD_NO 2'h2
`define AXS_FLD_UNK 2'h0
`define AXS_SIG_POS 2
`define AXS_CONN_POS 0
`define AXS_RST_ROUTE 2'h0

`endif

// file: hdl/axs_pkg.sv
`default_nettype none
package axs_pkg;
	typedef enum logic [2:0] {
		AXS_OP_NONE = 3'h0,
		AXS_OP_IN_STATUS = 3'h1,
		AXS_OP_OUT_STATUS = 3'h2,
		AXS_OP_ROUTE_LIST = 3'h3,
		AXS_OP_SWITCH = 3'h4,
		AXS_OP_SILENCE = 3'h5,
		AXS_OP_UNSILENCE = 3'h6
	} axs_op_type;

	typedef struct packed {
		axs_op_type op;
		logic [1:0] in_sel;
		logic [1:0] out_sel;
	} axs_cmd_type;

	typedef enum logic [1:0] {
		AXS_ST_IDLE = 2'b00,
		AXS_ST_EMIT = 2'b01,
		AXS_ST_WAIT = 2'b11
	} axs_state_type;
endpackage
`default_nettype wire

// file: hdl/axs_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module axs_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
	logic push, pop;

	always_comb begin
		in_ready_o = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
		out_valid_o = wr_reg != rd_reg;
		out_data_o = mem[rd_reg[AW-1:0]];
		push = in_valid_i && in_ready_o && ce_i;
		pop = out_valid_o && out_ready_i && ce_i;
		wr_next = push ? wr_reg + 1'b1 : wr_reg;
		rd_next = pop ? rd_reg + 1'b1 : rd_reg;
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_reg[AW-1:0]] <= in_data_i;
		end
		if (!rst_b_i) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
		end
	end
endmodule
`default_nettype wire

// file: hdl/axs_crosspoint.sv
`timescale 1ns/100ps
`default_nettype none
`include "axs_params.svh"
module axs_crosspoint
	import axs_pkg::*;
(
	// Clock, reset, enable
	input wire logic CORE_CLK_I,
	input wire logic RST_B_I,
	input wire logic CE_I,
	// Command port
	input wire axs_cmd_type CMD_I,
	input wire logic CMD_VALID_I,
	output logic CMD_READY_O,
	// Port state
	input wire logic [2:0] IN_LOCK_I,
	input wire logic [2:0] IN_SIG_I,
	input wire logic [2:0] IN_CONN_I,
	input wire logic [2:0] OUT_MUTE_I,
	input wire logic [2:0] OUT_LOCK_I,
	input wire logic [2:0] OUT_SIG_I,
	input wire logic [2:0] OUT_CONN_I,
	// Routing and mute state
	output logic [5:0] ROUTE_O,
	output logic [2:0] IN_MUTE_O,
	// Reply stream
	output logic [7:0] RSP_DATA_O,
	output logic RSP_VALID_O,
	input wire logic RSP_READY_I
);
	// --------------------------------------------------------
	// Helpers
	// --------------------------------------------------------
	function automatic logic [7:0] hex_char(input logic [3:0] v);
		hex_char = (v < 4'hA) ? 8'(8'h30 + 8'(v)) : 8'(8'h37 + 8'(v));
	endfunction

	function automatic logic [7:0] state_letter(input logic mute, input logic lock);
		unique case ({mute, lock}) // [RQ2]
			2'b00: state_letter = `AXS_CH_T;
			2'b01: state_letter = `AXS_CH_L;
			2'b10: state_letter = `AXS_CH_M;
			2'b11: state_letter = `AXS_CH_U;
		endcase
	endfunction

	function automatic logic [1:0] field(input logic known, input logic yes);
		field = !known ? `AXS_FLD_UNK : (yes ? `AXS_FLD_YES : `AXS_FLD_NO); // [RQ3]
	endfunction

	// --------------------------------------------------------
	// State
	// --------------------------------------------------------
	axs_state_type st_reg, st_next;
	axs_op_type op_reg, op_next;
	logic [1:0] route_reg [3];
	logic [1:0] route_next [3];
	logic [2:0] mute_reg, mute_next;
	logic [4:0] idx_reg, idx_next;
	logic [7:0] ch;
	logic last;
	logic push, fifo_ready;
	logic [7:0] fifo_data;
	logic fifo_valid;
	logic [3:0] nib [3];
	logic [7:0] let_ch [3];

	// Per-port token parts from live state, sampled while emitting
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_port
			always_comb begin
				if (op_reg == AXS_OP_IN_STATUS) begin
					// Inputs one and two have no connection pin [RQ4]
					nib[g] = {field(1'b1, IN_SIG_I[g]), field(g == 2, IN_CONN_I[g])}; // [RQ4]
					let_ch[g] = state_letter(mute_reg[g], IN_LOCK_I[g]); // [RQ11]
				end else begin
					nib[g] = {field(1'b1, OUT_SIG_I[g]), field(1'b1, OUT_CONN_I[g])};
					let_ch[g] = state_letter(OUT_MUTE_I[g], OUT_LOCK_I[g]);
				end
			end
		end
	endgenerate

	// --------------------------------------------------------
	// Reply character sequencer
	// --------------------------------------------------------
	always_comb begin
		logic [1:0] p;
		logic [2:0] k;
		p = 2'h0;
		k = 3'h0;
		ch = `AXS_CH_CR;
		last = 1'b0;
		unique case (op_reg)
			AXS_OP_IN_STATUS, AXS_OP_OUT_STATUS: begin
				// Six characters per port: letter, four hex, separator [RQ1] [RQ6]
				p = (idx_reg < 5'd6) ? 2'd0 : (idx_reg < 5'd12) ? 2'd1 : 2'd2;
				k = 3'(idx_reg - 5'(6 * p));
				unique case (k)
					3'd0: ch = let_ch[p];
					3'd1, 3'd2, 3'd3: ch = `AXS_CH_ZERO; // [RQ5]
					3'd4: ch = hex_char(nib[p]);
					default: ch = (p == 2'd2) ? `AXS_CH_CR : `AXS_CH_SEMI;
				endcase
				last = idx_reg == 5'd17;
			end
			AXS_OP_ROUTE_LIST: begin
				// Three characters per output: A, digit, separator [RQ7]
				p = (idx_reg < 5'd3) ? 2'd0 : (idx_reg < 5'd6) ? 2'd1 : 2'd2;
				k = 3'(idx_reg - 5'(3 * p));
				unique case (k)
					3'd0: ch = `AXS_CH_A;
					3'd1: ch = 8'(8'h31 + 8'(route_reg[p]));
					default: ch = (p == 2'd2) ? `AXS_CH_CR : `AXS_CH_SEMI;
				endcase
				last = idx_reg == 5'd8;
			end
			default: begin
				// Acknowledge for switch and mute commands [RQ8]
				ch = (idx_reg == 5'd0) ? `AXS_CH_K : `AXS_CH_CR;
				last = idx_reg == 5'd1;
			end
		endcase
	end

	// --------------------------------------------------------
	// Command handling
	// --------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		op_next = op_reg;
		idx_next = idx_reg;
		mute_next = mute_reg;
		route_next = route_reg;
		push = 1'b0;
		unique case (st_reg)
			AXS_ST_IDLE: begin
				// Ready stays low one cycle after reset, so nothing is taken then
				if (CMD_VALID_I && CMD_READY_O && CMD_I.op != AXS_OP_NONE) begin
					op_next = CMD_I.op;
					idx_next = 5'd0;
					st_next = AXS_ST_EMIT;
					// Out-of-range ports are ignored but still acknowledged
					if (CMD_I.op == AXS_OP_SWITCH && CMD_I.in_sel < 2'd3
						&& CMD_I.out_sel < 2'd3) begin
						route_next[CMD_I.out_sel] = CMD_I.in_sel; // [RQ8] [RQ9] [RQ10]
					end
					if (CMD_I.op == AXS_OP_SILENCE && CMD_I.in_sel < 2'd3) begin
						mute_next[CMD_I.in_sel] = 1'b1; // [RQ11]
					end
					if (CMD_I.op == AXS_OP_UNSILENCE && CMD_I.in_sel < 2'd3) begin
						mute_next[CMD_I.in_sel] = 1'b0; // [RQ11]
					end
				end
			end
			AXS_ST_EMIT: begin
				// Back-pressure from the reply FIFO stalls the sequencer
				if (fifo_ready) begin
					push = 1'b1;
					idx_next = 5'(idx_reg + 5'd1);
					if (last) begin
						st_next = AXS_ST_WAIT;
					end
				end
			end
			AXS_ST_WAIT: begin
				st_next = AXS_ST_IDLE;
			end
			default: st_next = AXS_ST_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_B_I) begin
			st_reg <= AXS_ST_IDLE;
			op_reg <= AXS_OP_NONE;
			idx_reg <= 5'd0;
			mute_reg <= 3'h0;
			for (int i = 0; i < 3; i++) begin
				route_reg[i] <= `AXS_RST_ROUTE;
			end
			CMD_READY_O <= 1'b0;
			ROUTE_O <= 6'h0;
			IN_MUTE_O <= 3'h0;
		end else if (CE_I) begin
			st_reg <= st_next;
			op_reg <= op_next;
			idx_reg <= idx_next;
			mute_reg <= mute_next;
			route_reg <= route_next;
			CMD_READY_O <= st_next == AXS_ST_IDLE;
			ROUTE_O <= {route_next[2], route_next[1], route_next[0]};
			IN_MUTE_O <= mute_next;
		end
	end

	// --------------------------------------------------------
	// Reply buffer
	// --------------------------------------------------------
	axs_fifo #(.WIDTH(8), .DEPTH(`AXS_FIFO_DEPTH)) u_fifo (
		.clk_i(CORE_CLK_I),
		.rst_b_i(RST_B_I),
		.ce_i(CE_I),
		.in_data_i(ch),
		.in_valid_i(push),
		.in_ready_o(fifo_ready),
		.out_data_o(fifo_data),
		.out_valid_o(fifo_valid),
		.out_ready_i(RSP_READY_I || !RSP_VALID_O)
	);

	// Output skid register keeps the reply port straight from a flop
	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_B_I) begin
			RSP_VALID_O <= 1'b0;
			RSP_DATA_O <= 8'h00;
		end else if (CE_I && (RSP_READY_I || !RSP_VALID_O)) begin
			RSP_VALID_O <= fifo_valid;
			RSP_DATA_O <= fifo_data;
		end
	end
endmodule
`default_nettype wire

// file: verification/axs_crosspoint_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module axs_crosspoint_asserts
	import axs_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic RST_B_I,
	input wire logic CE_I,
	input wire axs_cmd_type CMD_I,
	input wire logic CMD_VALID_I,
	input wire logic CMD_READY_O,
	input wire logic [5:0] ROUTE_O,
	input wire logic [2:0] IN_MUTE_O,
	input wire logic [7:0] RSP_DATA_O,
	input wire logic RSP_VALID_O,
	input wire logic RSP_READY_I
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_B_I);
	logic take;
	logic [1:0] o_reg;
	logic [1:0] i_reg;
	assign take = CMD_VALID_I && CMD_READY_O && CE_I && CMD_I.op != AXS_OP_NONE;
	// Selections of the last cycle, to index the fields
	always_ff @(posedge CORE_CLK_I) begin
		o_reg <= CMD_I.out_sel;
		i_reg <= CMD_I.in_sel;
	end
	sequence s_sw;
		take && CMD_I.op == AXS_OP_SWITCH && CMD_I.out_sel != 2'h3 && CMD_I.in_sel != 2'h3;
	endsequence
	sequence s_in(axs_op_type op);
		take && CMD_I.op == op && CMD_I.in_sel != 2'h3;
	endsequence
	a_switch_route: assert property (s_sw |=> ROUTE_O[2*o_reg+:2] == i_reg)
		else $error("route field not set");
	a_switch_others: assert property (
		s_sw |=> ((ROUTE_O ^ $past(ROUTE_O)) & ~(6'h03 << (2*o_reg))) == 6'h00)
		else $error("other route changed");
	a_route_hold: assert property (
		!(take && CMD_I.op == AXS_OP_SWITCH) |=> $stable(ROUTE_O))
		else $error("route moved");
	a_silence_set: assert property (s_in(AXS_OP_SILENCE) |=> IN_MUTE_O[i_reg])
		else $error("mute not set");
	a_silence_clr: assert property (s_in(AXS_OP_UNSILENCE) |=> !IN_MUTE_O[i_reg])
		else $error("mute not cleared");
	a_busy_take: assert property (take |=> (!CMD_READY_O) [*2])
		else $error("ready too soon");
	a_reply_hold: assert property (
		RSP_VALID_O && !RSP_READY_I |=> RSP_VALID_O && $stable(RSP_DATA_O))
		else $error("reply dropped");
	a_reply_char: assert property (RSP_VALID_O |-> RSP_DATA_O inside {
		8'h30, 8'h31, 8'h32, 8'h33,
		8'h38, 8'h41, 8'h42, 8'h43, 8'h45, 8'h46, 8'h54, 8'h4C, 8'h4D, 8'h55, 8'h3B, 8'h0D, 8'h4B})
		else $error("bad reply char");
endmodule
`default_nettype wire

// file: verification/axs_host.sv
`timescale 1ns/100ps
`default_nettype none
module axs_host
	import axs_pkg::*;
(
	input wire logic clk_i,
	input wire logic ready_i,
	input wire logic [7:0] rsp_i,
	input wire logic rsp_valid_i,
	input wire logic slow_i,
	input wire logic ce_i,
	output var axs_cmd_type cmd_o,
	output logic valid_o,
	output logic rsp_ready_o
);
	string rx;
	int cyc = 0;
	initial begin
		cmd_o = '0;
		valid_o = 1'b0;
		rsp_ready_o = 1'b0;
	end
	// Slow sink takes one char in 32, so a long reply fills the buffer
	always @(posedge clk_i) begin
		// A char only leaves on an enabled edge
		if (rsp_valid_i && rsp_ready_o && ce_i) rx = $sformatf("%s%c", rx, rsp_i);
		cyc <= cyc + 1;
		rsp_ready_o <= !slow_i || cyc[4:0] == 5'h00;
	end
	task automatic send(input axs_cmd_type c);
		int n;
		n = 0;
		rx = "";
		cmd_o <= c;
		valid_o <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (!(ready_i && ce_i) && n < 50);
		valid_o <= 1'b0;
		do begin
			@(posedge clk_i);
			n++;
		end while (!(ready_i && !rsp_valid_i) && n < 2000);
		repeat (4) @(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	import axs_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1;
	logic slow = 1'b0;
	logic [2:0] in_lock = '0, in_sig = '0, in_conn = '0;
	logic [2:0] o_mute = '0, o_lock = '0, o_sig = '0, o_conn = '0;
	axs_cmd_type cmd;
	logic cmd_valid, cmd_ready, rsp_valid, rsp_ready;
	logic [5:0] route;
	logic [2:0] in_mute;
	logic [7:0] rsp_data;
	int n_errors = 0;
	int compares = 0;
	always #4 clk = ~clk;
	axs_crosspoint i_axs_crosspoint (.CORE_CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce), .CMD_I(cmd),
		.CMD_VALID_I(cmd_valid), .CMD_READY_O(cmd_ready), .IN_LOCK_I(in_lock), .IN_SIG_I(in_sig),
		.IN_CONN_I(in_conn), .OUT_MUTE_I(o_mute), .OUT_LOCK_I(o_lock), .OUT_SIG_I(o_sig),
		.OUT_CONN_I(o_conn), .ROUTE_O(route), .IN_MUTE_O(in_mute), .RSP_DATA_O(rsp_data),
		.RSP_VALID_O(rsp_valid), .RSP_READY_I(rsp_ready));
	axs_host i_axs_host (.clk_i(clk), .ready_i(cmd_ready), .rsp_i(rsp_data), .rsp_valid_i(rsp_valid),
		.slow_i(slow), .ce_i(ce), .cmd_o(cmd), .valid_o(cmd_valid), .rsp_ready_o(rsp_ready));
	task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic run(axs_op_type op, logic [1:0] i, logic [1:0] o, string exp);
		i_axs_host.send('{op, i, o});
		compares++;
		if (i_axs_host.rx != exp) begin
			n_errors++;
			$display("MISMATCH reply expected %s seen %s", exp, i_axs_host.rx);
		end
	endtask
	task automatic t_reset;
		chk("route", 8'h00, {2'h0, route});
		chk("mute", 8'h00, {5'h0, in_mute});
		chk("ready", 8'h01, {7'h0, cmd_ready});
		run(AXS_OP_ROUTE_LIST, 2'h0, 2'h0, "A1;A1;A1\r");
	endtask
	task automatic t_switch;
		run(AXS_OP_SWITCH, 2'h2, 2'h0, "K\r");
		run(AXS_OP_SWITCH, 2'h1, 2'h1, "K\r");
		run(AXS_OP_SWITCH, 2'h1, 2'h2, "K\r");
		run(AXS_OP_SWITCH, 2'h0, 2'h3, "K\r");
		run(AXS_OP_NONE, 2'h0, 2'h1, "");
		chk("route", 8'h16, {2'h0, route});
		run(AXS_OP_ROUTE_LIST, 2'h0, 2'h0, "A3;A2;A2\r");
	endtask
	task automatic t_in_status;
		in_lock <= 3'b110;
		in_sig <= 3'b101;
		in_conn <= 3'b111;
		run(AXS_OP_SILENCE, 2'h2, 2'h0, "K\r");
		chk("mute", 8'h04, {5'h0, in_mute});
		run(AXS_OP_IN_STATUS, 2'h0, 2'h0, "T000C;L0008;U000F\r");
		run(AXS_OP_UNSILENCE, 2'h2, 2'h0, "K\r");
		run(AXS_OP_SILENCE, 2'h0, 2'h0, "K\r");
		run(AXS_OP_IN_STATUS, 2'h0, 2'h0, "M000C;L0008;L000F\r");
	endtask
	task automatic t_out_status;
		o_mute <= 3'b001;
		o_lock <= 3'b100;
		o_sig <= 3'b011;
		o_conn <= 3'b110;
		slow <= 1'b1;
		run(AXS_OP_OUT_STATUS, 2'h0, 2'h0, "M000E;T000F;L000B\r");
		slow <= 1'b0;
	endtask
	// Freeze in mid-reply: outputs must hold and the reply must stay whole
	task automatic t_freeze;
		logic [7:0] snap_data;
		logic [1:0] snap_flags;
		snap_data = 8'h00;
		snap_flags = 2'h0;
		fork
			run(AXS_OP_OUT_STATUS, 2'h0, 2'h0, "M000E;T000F;L000B\r");
			begin
				repeat (6) @(posedge clk);
				ce <= 1'b0;
				@(posedge clk);
				snap_data = rsp_data;
				snap_flags = {cmd_ready, rsp_valid};
				repeat (8) @(posedge clk);
				ce <= 1'b1;
				chk("frozen data", snap_data, rsp_data);
				chk("frozen flags", {6'h0, snap_flags}, {6'h0, cmd_ready, rsp_valid});
			end
		join
	endtask
	task automatic results;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset();
		t_switch();
		t_in_status();
		t_out_status();
		t_freeze();
		results();
	end
	// Whole run needs well under 3000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		results();
	end
endmodule
bind axs_crosspoint axs_crosspoint_asserts i_axs_crosspoint_asserts (.CORE_CLK_I(CORE_CLK_I),
	.RST_B_I(RST_B_I), .CE_I(CE_I), .CMD_I(CMD_I), .CMD_VALID_I(CMD_VALID_I),
	.CMD_READY_O(CMD_READY_O), .ROUTE_O(ROUTE_O), .IN_MUTE_O(IN_MUTE_O), .RSP_DATA_O(RSP_DATA_O),
	.RSP_VALID_O(RSP_VALID_O), .RSP_READY_I(RSP_READY_I));
`default_nettype wire
